/* cfg_regs_pkg.sv */
package cfg_regs_pkg;
    // ------------------------------------------------------------
    // register indices loaded through the configuration index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SERIAL_POWER   = 8'h02;
    localparam logic [7:0] IDX_FLOPPY_MISC    = 8'h03;
    localparam logic [7:0] IDX_PPORT_SER_MISC = 8'h04;
    localparam logic [7:0] IDX_RESET          = 8'h00;

    // ------------------------------------------------------------
    // reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SERIAL_POWER   = 8'h00;
    localparam logic [7:0] RST_FLOPPY_MISC    = 8'h70;
    localparam logic [7:0] RST_PPORT_SER_MISC = 8'h00;
    localparam logic [7:0] WMASK_SERIAL_POWER = 8'h8e; // bits 1,2,3,7
    localparam logic [7:0] WMASK_FLOPPY_MISC  = 8'h72; // bits 1,4,5,6
    localparam logic [7:0] WMASK_PPORT_SER    = 8'h7f; // bits 0..6
    localparam logic [7:0] ZERO_BYTE          = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PWR_A_BIT = 3;  // first serial port
    localparam int PWR_B_BIT = 7;  // second port and fast infrared
    localparam int PWR_C_BIT = 1;
    localparam int PWR_D_BIT = 2;
    localparam int FLP_ENH_BIT   = 1;
    localparam int FLP_DEN_BIT   = 4;
    localparam int FLP_MODE_LSB  = 5;
    localparam int PP_EXT_LSB    = 0;
    localparam int PP_FDC_LSB    = 2;
    localparam int MIDI_1_BIT    = 4;
    localparam int MIDI_2_BIT    = 5;
    localparam int EPP_REV_BIT   = 6;

    // ------------------------------------------------------------
    // mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] PP_SPP     = 2'h0;
    localparam logic [1:0] PP_EPP_SPP = 2'h1;
    localparam logic [1:0] PP_ECP     = 2'h2;
    localparam logic [1:0] PP_ECP_EPP = 2'h3;
    localparam logic [1:0] PPFD_NORMAL = 2'h0;
    localparam logic [1:0] PPFD_RSVD   = 2'h3;
    localparam logic [2:0] ECR_EPP     = 3'h4;
    localparam logic [2:0] ECR_SPP     = 3'h0;

    // ------------------------------------------------------------
    // timing: midi bit rate and the 16x serial sample clock
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int MIDI_BAUD     = 31_250;
    localparam int MIDI_OVS      = 16;
    localparam int MIDI_ERR_PCT  = 1;
endpackage : cfg_regs_pkg

/* midi_clk_if.sv */
// enable in, 16x sample tick out, one per midi port (two in all)
interface midi_clk_if;
    logic enable;  // midi clocking selected for the port
    logic tick;    // one-cycle sample tick

    modport gen  (input enable, output tick);
    modport user (output enable, input tick);
endinterface : midi_clk_if

/* midi_baud_gen.sv */
module midi_baud_gen #(
    parameter int CLK_HZ = cfg_regs_pkg::CLK_HZ
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // link to the register bank
    midi_clk_if.gen   link
);
    // ------------------------------------------------------------
    // divider sizing
    // ------------------------------------------------------------
    localparam int DIV = CLK_HZ /
        (cfg_regs_pkg::MIDI_BAUD * cfg_regs_pkg::MIDI_OVS);
    localparam int REAL_BAUD = CLK_HZ / (DIV * cfg_regs_pkg::MIDI_OVS);
    localparam int ERR = (REAL_BAUD > cfg_regs_pkg::MIDI_BAUD) ?
        REAL_BAUD - cfg_regs_pkg::MIDI_BAUD :
        cfg_regs_pkg::MIDI_BAUD - REAL_BAUD;
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] CZERO = '0;

    // refuse a clock that cannot reach the rate within the tolerance
    if (DIV < 2 || ERR * 100 >
        cfg_regs_pkg::MIDI_BAUD * cfg_regs_pkg::MIDI_ERR_PCT) begin : g_bad
        $error("midi_baud_gen: clock cannot make the midi rate");
    end

    logic [CW-1:0] cnt_ff;   // cycles within one tick period
    logic          tick_ff;  // registered tick
    wire           wrap = (cnt_ff == LAST);

    // counter held at zero while disabled so the first bit is aligned
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= CZERO;
            tick_ff <= 1'b0;
        end else if (clk_en) begin
            cnt_ff  <= (!link.enable || wrap) ? CZERO : cnt_ff + 1'b1;
            tick_ff <= link.enable && wrap;
        end
    end
    assign link.tick = tick_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [CW:0] gap_ff;   // enabled cycles since last tick
    logic        seen_ff;  // a tick already seen since enable
    // counts tick to tick, independent of the divider's own counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff  <= '0;
            seen_ff <= 1'b0;
        end else if (clk_en) begin
            gap_ff  <= (tick_ff || !link.enable) ? '0 : gap_ff + 1'b1;
            seen_ff <= link.enable && (seen_ff || tick_ff);
        end
    end
    // first tick after enable is skipped: its lead-in is one longer
    AST_MIDI_PERIOD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tick_ff && seen_ff |-> gap_ff == (CW+1)'(DIV - 1))
        else $error("midi tick period wrong");
    COV_MIDI_TICK: cover property (@(posedge sys_clk) disable iff (!rst_n)
        tick_ff);
endmodule : midi_baud_gen

/* uart_floppy_pport_config_regs.sv */
module uart_floppy_pport_config_regs #(
    parameter int CLK_HZ = cfg_regs_pkg::CLK_HZ
) (
    // clock, power-on reset, enable
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // hard reset pulse
    input  wire logic       hard_rst,
    // configuration access port
    input  wire logic       cfg_state,
    input  wire logic       index_wr,
    input  wire logic       data_wr,
    input  wire logic       data_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_ff,
    output logic            rd_valid_ff,
    output logic      [7:0] config_index_select_ff,
    // neighbouring control bits
    input  wire logic       pport_printer_mode,
    input  wire logic       floppy_output_tristate_ctl,
    input  wire logic [2:0] ecr_mode,
    input  wire logic       density_func,
    // serial port power
    output logic            serial_port_a_power_ff,
    output logic            serial_port_b_power_ff,
    output logic            serial_port_c_power_ff,
    output logic            serial_port_d_power_ff,
    output logic            fast_infrared_engine_en_ff,
    // floppy controls
    output logic            floppy_enh_mode2_ff,
    output logic      [1:0] floppy_if_mode_ff,
    output logic            drive_density_out_1_ff,
    output logic            drive_density_oe_ff,
    // parallel port controls
    output logic      [1:0] pport_ext_mode_ff,
    output logic      [1:0] pport_floppy_sel_ff,
    output logic            pport_epp_active_ff,
    output logic            pport_spp_active_ff,
    output logic            pport_two_drive_limit_ff,
    output logic            epp_rev_17_ff,
    // midi clocking
    output logic      [1:0] midi_enable_ff,
    output logic      [1:0] midi_tick_ff
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CLK_HZ < cfg_regs_pkg::MIDI_BAUD * cfg_regs_pkg::MIDI_OVS * 2)
    begin : g_bad_clk
        $error("config regs: clock too slow for midi tick");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] serial_power_ff;   // serial port power register
    logic [7:0] floppy_misc_ff;    // floppy misc register
    logic [7:0] pport_ser_ff;      // parallel/serial misc register

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // hit only in config state with the matching index loaded
    function automatic logic acc_hit(input logic       cfg,
                                     input logic [7:0] idx,
                                     input logic [7:0] want);
        acc_hit = cfg && (idx == want);
    endfunction : acc_hit

    wire hit_pwr = acc_hit(cfg_state, config_index_select_ff,
                           cfg_regs_pkg::IDX_SERIAL_POWER);
    wire hit_flp = acc_hit(cfg_state, config_index_select_ff,
                           cfg_regs_pkg::IDX_FLOPPY_MISC);
    wire hit_pps = acc_hit(cfg_state, config_index_select_ff,
                           cfg_regs_pkg::IDX_PPORT_SER_MISC);

    // index load takes priority; a data strobe in that cycle is dropped
    wire wr_ok   = data_wr && !index_wr;
    wire rd_ok   = data_rd && !index_wr;
    wire wr_pwr  = wr_ok && hit_pwr;
    wire wr_flp  = wr_ok && hit_flp;
    wire wr_pps  = wr_ok && hit_pps;
    wire rd_hit  = rd_ok && (hit_pwr || hit_flp || hit_pps);

    // writable bits only; reserved positions keep zero
    wire [7:0] wpwr = wdata & cfg_regs_pkg::WMASK_SERIAL_POWER;
    wire [7:0] wflp = wdata & cfg_regs_pkg::WMASK_FLOPPY_MISC;
    wire [7:0] wpps = wdata & cfg_regs_pkg::WMASK_PPORT_SER;

    // read mux; an unmatched index takes no read and rdata_ff holds its value
    wire [7:0] rd_word = hit_pwr ? serial_power_ff :
                         hit_flp ? floppy_misc_ff  :
                         hit_pps ? pport_ser_ff    :
                         cfg_regs_pkg::ZERO_BYTE;

    // ------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------
    // hard reset clears only serial power; others keep their bits
    wire [7:0] nxt_serial_power = hard_rst ?
        cfg_regs_pkg::RST_SERIAL_POWER :
        (wr_pwr ? wpwr : serial_power_ff);
    wire [7:0] nxt_floppy_misc  = wr_flp ? wflp : floppy_misc_ff;
    wire [7:0] nxt_pport_ser    = wr_pps ? wpps : pport_ser_ff;
    wire [7:0] nxt_index        = index_wr && cfg_state ? wdata :
                                  config_index_select_ff;

    // ------------------------------------------------------------
    // register flops
    // ------------------------------------------------------------
    // power-on values; the index is outside the hard-reset domain
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_power_ff        <= cfg_regs_pkg::RST_SERIAL_POWER;
            floppy_misc_ff         <= cfg_regs_pkg::RST_FLOPPY_MISC;
            pport_ser_ff           <= cfg_regs_pkg::RST_PPORT_SER_MISC;
            config_index_select_ff <= cfg_regs_pkg::IDX_RESET;
        end else if (clk_en) begin
            serial_power_ff        <= nxt_serial_power;
            floppy_misc_ff         <= nxt_floppy_misc;
            pport_ser_ff           <= nxt_pport_ser;
            config_index_select_ff <= nxt_index;
        end
    end

    // read data held until the next taken read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff    <= cfg_regs_pkg::ZERO_BYTE;
            rd_valid_ff <= 1'b0;
        end else if (clk_en) begin
            rd_valid_ff <= rd_hit;
            if (rd_hit) rdata_ff <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // serial port power outputs
    // ------------------------------------------------------------
    // a powered-down port keeps its address decode; decode is
    // owned by the port's base-address logic, not gated here
    localparam int PWR_POS [4] = '{cfg_regs_pkg::PWR_A_BIT,
                                   cfg_regs_pkg::PWR_B_BIT,
                                   cfg_regs_pkg::PWR_C_BIT,
                                   cfg_regs_pkg::PWR_D_BIT};
    // a,b,c,d enables; base-address decode stays outside
    logic [3:0] port_pwr_ff;
    for (genvar p = 0; p < 4; p++) begin : g_pwr
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) port_pwr_ff[p] <= 1'b0;
            else if (clk_en)
                port_pwr_ff[p] <= nxt_serial_power[PWR_POS[p]];
        end
    end
    assign serial_port_a_power_ff = port_pwr_ff[0];
    assign serial_port_b_power_ff = port_pwr_ff[1];
    assign serial_port_c_power_ff = port_pwr_ff[2];
    assign serial_port_d_power_ff = port_pwr_ff[3];

    // infrared engine follows the second port's power bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) fast_infrared_engine_en_ff <= 1'b0;
        else if (clk_en)
            fast_infrared_engine_en_ff <=
                nxt_serial_power[cfg_regs_pkg::PWR_B_BIT];
    end

    // ------------------------------------------------------------
    // floppy controls
    // ------------------------------------------------------------
    wire       den_force = floppy_misc_ff[cfg_regs_pkg::FLP_DEN_BIT];
    // tristate control wins; force only matters while driving
    wire       nxt_den   = den_force ? 1'b1 : density_func;
    wire       nxt_den_oe = !floppy_output_tristate_ctl;

    // interface mode 10 is reserved; passed through unchanged
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            floppy_enh_mode2_ff    <= 1'b0;
            floppy_if_mode_ff      <= 2'h3;
            drive_density_out_1_ff <= 1'b1;
            drive_density_oe_ff    <= 1'b0;
        end else if (clk_en) begin
            floppy_enh_mode2_ff    <=
                floppy_misc_ff[cfg_regs_pkg::FLP_ENH_BIT];
            floppy_if_mode_ff      <=
                floppy_misc_ff[cfg_regs_pkg::FLP_MODE_LSB +: 2];
            drive_density_out_1_ff <= nxt_den;
            drive_density_oe_ff    <= nxt_den_oe;
        end
    end

    // ------------------------------------------------------------
    // parallel port controls
    // ------------------------------------------------------------
    wire [1:0] ext_sel = pport_ser_ff[cfg_regs_pkg::PP_EXT_LSB +: 2];
    wire [1:0] fdc_sel = pport_ser_ff[cfg_regs_pkg::PP_FDC_LSB +: 2];
    // printer mode pins the port to standard mode
    wire [1:0] nxt_ext = pport_printer_mode ?
                         cfg_regs_pkg::PP_SPP : ext_sel;
    wire       ecp_set = (nxt_ext == cfg_regs_pkg::PP_ECP) ||
                         (nxt_ext == cfg_regs_pkg::PP_ECP_EPP);
    // epp via ecr only in the combined setting
    wire       nxt_epp = (nxt_ext == cfg_regs_pkg::PP_ECP_EPP) &&
                         (ecr_mode == cfg_regs_pkg::ECR_EPP);
    wire       nxt_spp = ecp_set &&
                         (ecr_mode == cfg_regs_pkg::ECR_SPP);
    // reserved variant is treated as normal use
    wire [1:0] nxt_fdc = (fdc_sel == cfg_regs_pkg::PPFD_RSVD) ?
                         cfg_regs_pkg::PPFD_NORMAL : fdc_sel;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pport_ext_mode_ff        <= cfg_regs_pkg::PP_SPP;
            pport_floppy_sel_ff      <= cfg_regs_pkg::PPFD_NORMAL;
            pport_epp_active_ff      <= 1'b0;
            pport_spp_active_ff      <= 1'b0;
            pport_two_drive_limit_ff <= 1'b0;
            epp_rev_17_ff            <= 1'b0;
        end else if (clk_en) begin
            pport_ext_mode_ff        <= nxt_ext;
            pport_floppy_sel_ff      <= nxt_fdc;
            pport_epp_active_ff      <= nxt_epp;
            pport_spp_active_ff      <= nxt_spp;
            // beyond two drives the board needs external logic
            pport_two_drive_limit_ff <= ecp_set;
            epp_rev_17_ff            <=
                pport_ser_ff[cfg_regs_pkg::EPP_REV_BIT];
        end
    end

    // ------------------------------------------------------------
    // midi clocking, one divider per port
    // ------------------------------------------------------------
    localparam int MIDI_POS [2] = '{cfg_regs_pkg::MIDI_1_BIT,
                                    cfg_regs_pkg::MIDI_2_BIT};
    for (genvar m = 0; m < 2; m++) begin : g_midi
        midi_clk_if lnk ();
        assign lnk.enable = pport_ser_ff[MIDI_POS[m]];
        midi_baud_gen #(.CLK_HZ(CLK_HZ)) u_gen (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .clk_en  (clk_en),
            .link    (lnk)
        );
        // retimed so outputs come from flops; adds one cycle
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                midi_enable_ff[m] <= 1'b0;
                midi_tick_ff[m]   <= 1'b0;
            end else if (clk_en) begin
                midi_enable_ff[m] <= lnk.enable;
                midi_tick_ff[m]   <= lnk.tick;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_NO_WR_OUTSIDE: assert property (
        clk_en && data_wr && !cfg_state && !hard_rst
        |=> $stable(serial_power_ff) && $stable(floppy_misc_ff)
            && $stable(pport_ser_ff))
        else $error("write taken outside config state");
    AST_HARD_CLEAR: assert property (
        clk_en && hard_rst |=> serial_power_ff == 8'h00
        && !serial_port_b_power_ff && !fast_infrared_engine_en_ff)
        else $error("hard reset left serial power set");
    AST_RSVD_ZERO: assert property (
        (serial_power_ff & ~cfg_regs_pkg::WMASK_SERIAL_POWER) == 8'h00
        && (floppy_misc_ff & ~cfg_regs_pkg::WMASK_FLOPPY_MISC) == 8'h00
        && pport_ser_ff[7] == 1'b0)
        else $error("reserved bit set");
    AST_PWR_FOLLOW: assert property (
        clk_en && wr_pwr && !hard_rst
        |=> serial_port_a_power_ff == $past(wdata[3])
            && serial_port_c_power_ff == $past(wdata[1]))
        else $error("serial power output wrong");
    AST_IR_WITH_B: assert property (
        fast_infrared_engine_en_ff == serial_port_b_power_ff)
        else $error("infrared not tied to second port");
    AST_DEN_FORCE: assert property (
        clk_en && den_force && !floppy_output_tristate_ctl
        |=> drive_density_out_1_ff && drive_density_oe_ff)
        else $error("density not forced high");
    AST_DEN_TRI: assert property (
        clk_en && floppy_output_tristate_ctl |=> !drive_density_oe_ff)
        else $error("density pin driven while tristated");
    AST_PRINTER: assert property (
        clk_en && pport_printer_mode
        |=> pport_ext_mode_ff == 2'h0 && !pport_epp_active_ff)
        else $error("extended mode in printer mode");
    AST_EPP_ENTRY: assert property (
        clk_en && !pport_printer_mode && ext_sel == 2'h3
        && ecr_mode == 3'h4 |=> pport_epp_active_ff)
        else $error("epp not entered");
    AST_READ_BACK: assert property (
        clk_en && rd_hit && hit_flp
        |=> rd_valid_ff && rdata_ff == $past(floppy_misc_ff))
        else $error("read data wrong");
    // index only moves in config state
    AST_INDEX_HOLD: assert property (
        clk_en && index_wr && !cfg_state
        |=> $stable(config_index_select_ff))
        else $error("index loaded outside config state");
    // ecr 000 drops either ecp setting back to standard mode
    AST_SPP_ENTRY: assert property (
        clk_en && !pport_printer_mode && ext_sel[1]
        && ecr_mode == cfg_regs_pkg::ECR_SPP |=> pport_spp_active_ff)
        else $error("spp not entered");
    // reserved floppy-on-port code must never reach the port
    AST_FDC_RSVD: assert property (
        clk_en && fdc_sel == cfg_regs_pkg::PPFD_RSVD
        |=> pport_floppy_sel_ff == cfg_regs_pkg::PPFD_NORMAL)
        else $error("reserved floppy-on-port code passed");
    // both ecp settings flag the two-drive limit
    AST_TWO_DRIVE: assert property (
        clk_en && !pport_printer_mode && ext_sel[1]
        |=> pport_two_drive_limit_ff)
        else $error("two-drive limit not flagged");

    COV_WR_POWER: cover property (clk_en && wr_pwr && wdata[7]);
    COV_READ: cover property (rd_valid_ff);
    COV_EPP: cover property (pport_epp_active_ff);
    COV_MIDI: cover property (midi_tick_ff[1]);
endmodule : uart_floppy_pport_config_regs

/* tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // design hookup
    // ----------------------------------------------------------------
    logic       sys_clk, rst_n, clk_en, hard_rst, cfg_state;
    logic       index_wr, data_wr, data_rd, pport_printer_mode;
    logic       floppy_output_tristate_ctl, density_func;
    logic [7:0] wdata, rdata_ff, config_index_select_ff;
    logic [2:0] ecr_mode;
    logic       rd_valid_ff, serial_port_a_power_ff, serial_port_b_power_ff;
    logic       serial_port_c_power_ff, serial_port_d_power_ff;
    logic       fast_infrared_engine_en_ff, floppy_enh_mode2_ff;
    logic       drive_density_out_1_ff, drive_density_oe_ff, epp_rev_17_ff;
    logic       pport_epp_active_ff, pport_spp_active_ff;
    logic       pport_two_drive_limit_ff;
    logic [1:0] floppy_if_mode_ff, pport_ext_mode_ff, pport_floppy_sel_ff;
    logic [1:0] midi_enable_ff, midi_tick_ff;
    int         error_cnt, n_compared, n;
    uart_floppy_pport_config_regs u_uart_floppy_pport_config_regs (
        .sys_clk, .rst_n, .clk_en, .hard_rst, .cfg_state, .index_wr,
        .data_wr, .data_rd, .wdata, .rdata_ff, .rd_valid_ff,
        .config_index_select_ff, .pport_printer_mode,
        .floppy_output_tristate_ctl, .ecr_mode, .density_func,
        .serial_port_a_power_ff, .serial_port_b_power_ff,
        .serial_port_c_power_ff, .serial_port_d_power_ff,
        .fast_infrared_engine_en_ff, .floppy_enh_mode2_ff,
        .floppy_if_mode_ff, .drive_density_out_1_ff, .drive_density_oe_ff,
        .pport_ext_mode_ff, .pport_floppy_sel_ff, .pport_epp_active_ff,
        .pport_spp_active_ff, .pport_two_drive_limit_ff, .epp_rev_17_ff,
        .midi_enable_ff, .midi_tick_ff);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // access tasks: inputs move 1 ns after the rising edge
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc
    // strobes are held across one edge; the next call replaces them
    task automatic acc(input logic [2:0] s, input logic [7:0] d);
        {index_wr, data_wr, data_rd} = s;
        wdata = d;
        cyc(1);
    endtask : acc
    task automatic idle();
        acc(3'b000, 8'h00);
    endtask : idle
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        acc(3'b100, idx);
        acc(3'b010, val);
        idle();
        cyc(1); // derived outputs settle one edge later
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        acc(3'b100, idx);
        acc(3'b001, 8'h00);
        check({7'h00, rd_valid_ff}, 8'h01);
        check(rdata_ff, exp);
        idle();
    endtask : rd
    // bounded wait for a midi tick on port 1
    task automatic wait_tick(output int k);
        k = 0;
        while (midi_tick_ff[0] !== 1'b1) begin
            cyc(1);
            k++;
            if (k > 400) begin
                error_cnt++;
                end_of_test();
            end
        end
    endtask : wait_tick
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, clk_en, hard_rst, index_wr, data_wr, data_rd} = 6'b010000;
        {cfg_state, pport_printer_mode, floppy_output_tristate_ctl} = 3'b100;
        {wdata, ecr_mode, density_func, error_cnt, n_compared} = '0;
        cyc(3);
        rst_n = 1'b1;
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h70);
        rd(8'h04, 8'h00);
        check({6'h0, floppy_if_mode_ff}, 8'h03);
        $display("test reset done");
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h8e);
        check({3'h0, serial_port_a_power_ff, serial_port_b_power_ff,
               serial_port_c_power_ff, serial_port_d_power_ff,
               fast_infrared_engine_en_ff}, 8'h1f);
        wr(8'h03, 8'hff);
        hard_rst = 1'b1;
        cyc(1);
        hard_rst = 1'b0;
        cyc(1);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h72);
        check({7'h0, serial_port_b_power_ff}, 8'h00);
        cfg_state = 1'b0;
        wr(8'h02, 8'h8e);
        check(config_index_select_ff, 8'h03);
        cfg_state = 1'b1;
        rd(8'h02, 8'h00);
        acc(3'b100, 8'h05);
        acc(3'b001, 8'h00);
        check({7'h0, rd_valid_ff}, 8'h00);
        idle();
        clk_en = 1'b0;
        wr(8'h02, 8'h8e);
        clk_en = 1'b1;
        check(config_index_select_ff, 8'h05);
        rd(8'h02, 8'h00);
        $display("test serial power done");
        check({5'h0, floppy_enh_mode2_ff, floppy_if_mode_ff}, 8'h07);
        check({6'h0, drive_density_out_1_ff, drive_density_oe_ff},
              8'h03);
        wr(8'h03, 8'h20);
        check({5'h0, floppy_enh_mode2_ff, floppy_if_mode_ff}, 8'h01);
        check({7'h0, drive_density_out_1_ff}, 8'h00);
        density_func = 1'b1;
        cyc(2);
        check({7'h0, drive_density_out_1_ff}, 8'h01);
        floppy_output_tristate_ctl = 1'b1;
        cyc(2);
        check({7'h0, drive_density_oe_ff}, 8'h00);
        $display("test floppy done");
        for (int m = 0; m < 4; m++) begin
            ecr_mode = m[0] ? 3'h4 : 3'h0;
            wr(8'h04, 8'(m) | 8'h48);
            check({4'h0, pport_ext_mode_ff, pport_floppy_sel_ff},
                  8'(m << 2) | 8'h02);
            check({5'h0, pport_epp_active_ff, pport_spp_active_ff,
                   pport_two_drive_limit_ff},
                  {5'h0, m == 3, m == 2, m[1]});
            check({7'h0, epp_rev_17_ff}, 8'h01);
        end
        pport_printer_mode = 1'b1;
        cyc(2);
        check({6'h0, pport_ext_mode_ff}, 8'h00);
        wr(8'h04, 8'hbc);
        rd(8'h04, 8'h3c);
        check({6'h0, pport_floppy_sel_ff}, 8'h00);
        check({6'h0, midi_enable_ff}, 8'h03);
        $display("test parallel done");
        wait_tick(n);
        cyc(1);
        wait_tick(n);
        check({6'h0, midi_tick_ff}, 8'h03);
        check(8'(n + 1), 8'hc8);
        $display("test midi done");
        end_of_test();
    end
endmodule : tb_top
